// >>> ltds_pkg.sv
// Package: constants and types for the local time and summer time logic
package ltds_pkg;
    localparam logic [3:0] MON_JAN = 4'h1;
    localparam logic [3:0] MON_MAR = 4'h3;
    localparam logic [3:0] MON_NOV = 4'hb;
    localparam logic [3:0] MON_DEC = 4'hc;
    localparam logic [2:0] WEEK_FIRST = 3'h1;
    localparam logic [2:0] WEEK_SECOND = 3'h2;
    localparam logic [2:0] WEEK_LAST = 3'h5;
    localparam logic [2:0] DAY_SUNDAY = 3'h0;
    localparam logic [2:0] DAY_SATURDAY = 3'h6;
    localparam logic [4:0] HOUR_MIN_DST = 5'h01;
    localparam logic [4:0] HOUR_MAX_DST = 5'h06;
    localparam logic [4:0] HOUR_DEF_DST = 5'h02;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [5:0] MIN_LAST = 6'h3b;
    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [5:0] SEC_HALF = 6'h1e;
    localparam logic [4:0] DAY_ONE = 5'h01;
    localparam logic [4:0] DAYS_IN_WEEK = 5'h07;
    localparam logic [6:0] YEAR_LAST = 7'h63;
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_MAX_LOW = 4'h7;
    localparam logic [3:0] SRC_FOURTEEN = 4'he;
    localparam logic [7:0] COUNTRY_DEFAULT = 8'h00;
    localparam int TICK_HZ = 1;
    localparam int CLK_HZ = 20000000;
    localparam int CYC_PER_SEC = CLK_HZ / TICK_HZ;

    typedef enum logic [1:0] {
        ORDER_DMY,
        ORDER_MDY,
        ORDER_YMD
    } ltds_order_t;

    typedef struct packed {
        logic [3:0] month;
        logic [2:0] week;
        logic [2:0] weekday;
        logic [4:0] hour;
    } ltds_point_t;

    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [2:0] weekday;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } ltds_time_t;

    localparam ltds_point_t START_DEFAULT = '{MON_MAR, WEEK_SECOND, DAY_SUNDAY, HOUR_DEF_DST};
    localparam ltds_point_t END_DEFAULT = '{MON_NOV, WEEK_FIRST, DAY_SUNDAY, HOUR_DEF_DST};
endpackage

// >>> ltds_sync.sv
// Synchroniser and edge detector for the selected minute pulse input
`timescale 1ns/100ps
module ltds_sync #(
    parameter int N = 14
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [N-1:0] sense_in, // Raw sense inputs
    input wire logic [3:0] src_sel, // Selected source
    output logic edge_seen // One-cycle pulse on rising edge
);
    logic [N-1:0] meta;
    logic [N-1:0] stable;
    logic sel_level;
    logic sel_prev;
    logic [3:0] sel_prev_src;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= '0;
            stable <= '0;
        end else begin
            meta <= sense_in;
            stable <= meta;
        end
    end

    always_comb begin
        sel_level = 1'b0;
        if (src_sel != ltds_pkg::SRC_NONE && src_sel <= 4'(N)) begin
            sel_level = stable[src_sel - 4'h1];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_prev <= 1'b0;
            sel_prev_src <= ltds_pkg::SRC_NONE;
            edge_seen <= 1'b0;
        end else begin
            sel_prev <= sel_level;
            sel_prev_src <= src_sel;
            edge_seen <= sel_level && !sel_prev && (sel_prev_src == src_sel);
        end
    end
endmodule

// >>> ltds_core.sv
// Local time keeping with summer time shifts and minute pulse snapping
`timescale 1ns/100ps
module ltds_core #(
    parameter int CYC_PER_SEC = ltds_pkg::CYC_PER_SEC
) (
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic dst_enable, // Summer time adjustment enable
    input wire ltds_pkg::ltds_point_t start_cfg, // Summer time start point
    input wire ltds_pkg::ltds_point_t summer_time_end_date, // Summer time end point
    input wire logic cfg_load, // Load new start/end/order/country/source
    input wire logic [3:0] sync_src, // 0 none, 1-7 or 14
    input wire ltds_pkg::ltds_order_t order_cfg, // Date order selection
    input wire logic [7:0] country_cfg, // Country calendar code
    input wire logic [13:0] sense_in, // Sense inputs, bit 0 is input one
    input wire logic time_load, // Load time_set into the clock
    input wire ltds_pkg::ltds_time_t time_set, // Time to load
    output ltds_pkg::ltds_time_t time_now, // Current local time
    output logic [17:0] date_view, // Date fields in chosen order, 6 bits each
    output logic dst_active, // Summer time in force
    output ltds_pkg::ltds_point_t start_now, // Start point in use
    output ltds_pkg::ltds_point_t end_now, // End point in use
    output logic [3:0] sync_now, // Sync source in use
    output logic [7:0] country_now, // Country code in use
    output logic sync_hit // Pulse when a snap is applied
);
    ltds_pkg::ltds_order_t order_now;
    logic [$clog2(CYC_PER_SEC)-1:0] div_cnt;
    logic sec_tick;
    logic pulse_edge;
    logic [4:0] days_in_month;
    logic last_day;
    logic [2:0] week_of_day;
    logic is_last_week;
    logic at_start;
    logic at_end;
    logic [6:0] shifted_year;
    logic end_done;
    logic round_up;
    logic step;
    logic start_hit;
    logic end_hit;
    logic year_wrap;
    ltds_pkg::ltds_time_t base;
    ltds_pkg::ltds_time_t next_time;

    function automatic logic src_ok(input logic [3:0] s);
        return s <= ltds_pkg::SRC_MAX_LOW || s == ltds_pkg::SRC_FOURTEEN;
    endfunction

    function automatic logic week_match(input logic [2:0] w, input logic [2:0] wk,
                                        input logic last);
        return (w == ltds_pkg::WEEK_LAST) ? last : (w == wk);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_now <= ltds_pkg::START_DEFAULT;
            end_now <= ltds_pkg::END_DEFAULT;
            sync_now <= ltds_pkg::SRC_NONE;
            order_now <= ltds_pkg::ORDER_DMY;
            country_now <= ltds_pkg::COUNTRY_DEFAULT;
        end else if (cfg_load) begin
            if (start_cfg.hour >= ltds_pkg::HOUR_MIN_DST && start_cfg.hour <= ltds_pkg::HOUR_MAX_DST
                && start_cfg.month >= ltds_pkg::MON_JAN && start_cfg.month <= ltds_pkg::MON_DEC
                && start_cfg.week >= ltds_pkg::WEEK_FIRST && start_cfg.week <= ltds_pkg::WEEK_LAST
                && start_cfg.weekday <= ltds_pkg::DAY_SATURDAY) begin
                start_now <= start_cfg;
            end
            if (summer_time_end_date.hour >= ltds_pkg::HOUR_MIN_DST
                && summer_time_end_date.hour <= ltds_pkg::HOUR_MAX_DST
                && summer_time_end_date.month >= ltds_pkg::MON_JAN
                && summer_time_end_date.month <= ltds_pkg::MON_DEC
                && summer_time_end_date.week >= ltds_pkg::WEEK_FIRST
                && summer_time_end_date.week <= ltds_pkg::WEEK_LAST
                && summer_time_end_date.weekday <= ltds_pkg::DAY_SATURDAY) begin
                end_now <= summer_time_end_date;
            end
            if (src_ok(sync_src)) begin
                sync_now <= sync_src;
            end
            if (order_cfg != ltds_pkg::ltds_order_t'(2'h3)) begin
                order_now <= order_cfg;
            end
            country_now <= country_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Second divider and pulse edge
    always_ff @(posedge clk_sys) begin
        if (rst || time_load || pulse_edge) begin
            div_cnt <= '0;
            sec_tick <= 1'b0;
        end else if (div_cnt == ($clog2(CYC_PER_SEC))'(CYC_PER_SEC - 1)) begin
            div_cnt <= '0;
            sec_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            sec_tick <= 1'b0;
        end
    end

    ltds_sync #(.N(14)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .sense_in(sense_in),
        .src_sel(sync_now),
        .edge_seen(pulse_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Calendar helpers
    always_comb begin
        unique case (time_now.month)
            4'h4, 4'h6, 4'h9, 4'hb: days_in_month = 5'h1e;
            4'h2: days_in_month = (time_now.year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            default: days_in_month = 5'h1f;
        endcase
        last_day = time_now.day >= days_in_month;
        week_of_day = 3'((time_now.day - ltds_pkg::DAY_ONE) / ltds_pkg::DAYS_IN_WEEK) + 3'h1;
        is_last_week = time_now.day > 5'(days_in_month - ltds_pkg::DAYS_IN_WEEK);
        // Snap rounds up by stepping from the last second of the minute
        round_up = pulse_edge && time_now.second >= ltds_pkg::SEC_HALF;
        step = round_up || (sec_tick && !pulse_edge);
        base = time_now;
        if (pulse_edge) begin
            base.second = round_up ? ltds_pkg::SEC_LAST : 6'h00;
        end
        at_start = time_now.month == start_now.month && time_now.weekday == start_now.weekday
            && week_match(start_now.week, week_of_day, is_last_week)
            && base.hour == 5'(start_now.hour - 5'h1) && base.minute == ltds_pkg::MIN_LAST
            && base.second == ltds_pkg::SEC_LAST;
        at_end = time_now.month == end_now.month && time_now.weekday == end_now.weekday
            && week_match(end_now.week, week_of_day, is_last_week)
            && base.hour == 5'(end_now.hour - 5'h1) && base.minute == ltds_pkg::MIN_LAST
            && base.second == ltds_pkg::SEC_LAST;
        shifted_year = (time_now.year == ltds_pkg::YEAR_LAST) ? 7'h00 : 7'(time_now.year + 7'h1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next time: one second step, summer time shift and minute snapping
    always_comb begin
        next_time = base;
        start_hit = 1'b0;
        end_hit = 1'b0;
        year_wrap = 1'b0;
        if (step && base.second != ltds_pkg::SEC_LAST) begin
            next_time.second = 6'(base.second + 6'h1);
        end else if (step) begin
            next_time.second = 6'h00;
            if (base.minute != ltds_pkg::MIN_LAST) begin
                next_time.minute = 6'(base.minute + 6'h1);
            end else begin
                next_time.minute = 6'h00;
                if (dst_enable && !dst_active && at_start) begin
                    next_time.hour = 5'(base.hour + 5'h2);
                    start_hit = 1'b1;
                end else if (dst_enable && dst_active && at_end && !end_done) begin
                    end_hit = 1'b1;
                end else if (base.hour != ltds_pkg::HOUR_LAST) begin
                    next_time.hour = 5'(base.hour + 5'h1);
                end else begin
                    next_time.hour = 5'h00;
                    next_time.weekday = (base.weekday == ltds_pkg::DAY_SATURDAY) ?
                        ltds_pkg::DAY_SUNDAY : 3'(base.weekday + 3'h1);
                    if (!last_day) begin
                        next_time.day = 5'(base.day + 5'h1);
                    end else begin
                        next_time.day = ltds_pkg::DAY_ONE;
                        if (base.month != ltds_pkg::MON_DEC) begin
                            next_time.month = 4'(base.month + 4'h1);
                        end else begin
                            next_time.month = ltds_pkg::MON_JAN;
                            next_time.year = shifted_year;
                            year_wrap = 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            time_now <= '{7'h00, ltds_pkg::MON_JAN, ltds_pkg::DAY_ONE, ltds_pkg::DAY_SUNDAY,
                          5'h00, 6'h00, 6'h00};
        end else if (time_load) begin
            time_now <= time_set;
        end else begin
            time_now <= next_time;
        end
    end

    // Disabling drops the flag without moving the clock
    always_ff @(posedge clk_sys) begin
        if (rst || !dst_enable) begin
            dst_active <= 1'b0;
        end else if (!time_load && start_hit) begin
            dst_active <= 1'b1;
        end else if (!time_load && end_hit) begin
            dst_active <= 1'b0;
        end
    end

    // End shift armed once a year so the repeated hour runs plainly
    always_ff @(posedge clk_sys) begin
        if (rst || time_load || year_wrap) begin
            end_done <= 1'b0;
        end else if (end_hit) begin
            end_done <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || time_load) begin
            sync_hit <= 1'b0;
        end else begin
            sync_hit <= pulse_edge;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Date presentation
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            date_view <= '0;
        end else begin
            unique case (order_now)
                ltds_pkg::ORDER_MDY: date_view <= {2'h0, time_now.month, 1'b0, time_now.day,
                                                   time_now.year[5:0]};
                ltds_pkg::ORDER_YMD: date_view <= {time_now.year[5:0], 2'h0, time_now.month,
                                                   1'b0, time_now.day};
                default: date_view <= {1'b0, time_now.day, 2'h0, time_now.month,
                                       time_now.year[5:0]};
            endcase
        end
    end
endmodule

// >>> ltds_monitor.sv
// Checker on the ports of the local time core
`timescale 1ns/100ps
module ltds_monitor (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic dst_enable, // Summer time enable
    input wire logic cfg_load, // Config load
    input wire logic [7:0] country_cfg, // Country code in
    input wire logic time_load, // Time load
    input wire ltds_pkg::ltds_time_t time_now, // Local time
    input wire logic dst_active, // Summer time flag
    input wire ltds_pkg::ltds_point_t start_now, // Start point
    input wire ltds_pkg::ltds_point_t end_now, // End point
    input wire logic [3:0] sync_now, // Sync source
    input wire logic [7:0] country_now, // Country in use
    input wire logic sync_hit // Snap pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_dst_off: assert property (!dst_enable ##1 !dst_enable |-> !dst_active)
        else $error("summer time flag set while disabled");
    a_no_jump: assert property (!dst_enable && !time_load |=>
        time_now.hour != $past(time_now.hour) + 5'h02) else $error("hour jumped while disabled");
    a_fwd_flag: assert property (dst_enable && !time_load ##1
        time_now.hour == $past(time_now.hour) + 5'h02 |-> dst_active) else $error("jump without flag");
    a_start_default: assert property ($fell(rst) |-> start_now == ltds_pkg::START_DEFAULT)
        else $error("start point reset value wrong");
    a_end_default: assert property ($fell(rst) |-> end_now == ltds_pkg::END_DEFAULT)
        else $error("end point reset value wrong");
    a_src_legal: assert property (sync_now <= 4'h7 || sync_now == 4'he)
        else $error("illegal sync source in use");
    a_src_default: assert property ($fell(rst) |-> sync_now == ltds_pkg::SRC_NONE)
        else $error("sync source reset value wrong");
    a_snap_zero: assert property (sync_hit |-> time_now.second == 6'h00 && sync_now != 4'h0)
        else $error("snap not on whole minute");
    a_cty_load: assert property (cfg_load |=> country_now == $past(country_cfg))
        else $error("country code not loaded");
endmodule

// >>> ltds_pulse_src.sv
// One-shot minute pulse source driving the sense pins
`timescale 1ns/100ps
module ltds_pulse_src (
    input wire logic clk_sys, // System clock
    input wire logic fire, // Start one pulse
    input wire logic [3:0] src, // Sense input 1-7 or 14
    input wire logic [3:0] width, // Pulse length in cycles
    output logic [13:0] sense_in // Sense pins
);
    logic [3:0] cnt = 4'h0;
    always @(posedge clk_sys) begin
        if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (fire) begin
            cnt <= width;
        end
    end
    // Pulled-down pins rest low between pulses
    assign sense_in = (cnt != 4'h0) ? 14'h0001 << (src - 4'h1) : 14'h0000;
endmodule

// >>> testbench.sv
// Self-checking bench for the local time core
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic dst_enable = 1'b0;
    ltds_pkg::ltds_point_t start_cfg = ltds_pkg::START_DEFAULT;
    ltds_pkg::ltds_point_t summer_time_end_date = ltds_pkg::END_DEFAULT;
    logic cfg_load = 1'b0;
    logic [3:0] sync_src = 4'h0;
    ltds_pkg::ltds_order_t order_cfg = ltds_pkg::ORDER_DMY;
    logic [7:0] country_cfg = 8'h00;
    logic [13:0] sense_in;
    logic time_load = 1'b0;
    ltds_pkg::ltds_time_t time_set = '0;
    ltds_pkg::ltds_time_t time_now;
    ltds_pkg::ltds_time_t prev_now;
    logic [17:0] date_view;
    logic dst_active;
    ltds_pkg::ltds_point_t start_now;
    ltds_pkg::ltds_point_t end_now;
    logic [3:0] sync_now;
    logic [7:0] country_now;
    logic sync_hit;
    logic fire = 1'b0;
    logic [3:0] pulse_src = 4'h1;
    logic [3:0] width = 4'h2;
    logic [3:0] srcs [$] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'he};
    logic [17:0] exp_view;
    logic [4:0] set_day = 5'h0a;
    logic got;
    int err_count = 0;
    int n_compared = 0;
    ltds_core #(.CYC_PER_SEC(4)) u_ltds_core (
        .clk_sys(clk_sys),
        .rst(rst),
        .dst_enable(dst_enable),
        .start_cfg(start_cfg),
        .summer_time_end_date(summer_time_end_date),
        .cfg_load(cfg_load),
        .sync_src(sync_src),
        .order_cfg(order_cfg),
        .country_cfg(country_cfg),
        .sense_in(sense_in),
        .time_load(time_load),
        .time_set(time_set),
        .time_now(time_now),
        .date_view(date_view),
        .dst_active(dst_active),
        .start_now(start_now),
        .end_now(end_now),
        .sync_now(sync_now),
        .country_now(country_now),
        .sync_hit(sync_hit)
    );
    ltds_pulse_src u_ltds_pulse_src (.clk_sys, .fire, .src(pulse_src), .width, .sense_in);
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) prev_now <= time_now;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_cfg(input logic [3:0] src, input logic [1:0] ord, input logic [7:0] cty);
        sync_src = src;
        order_cfg = ltds_pkg::ltds_order_t'(ord);
        country_cfg = cty;
        cfg_load = 1'b1;
        @(negedge clk_sys);
        cfg_load = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic set_time(input logic [4:0] hr, input logic [5:0] mi, input logic [5:0] se);
        time_set = '{7'h18, 4'h3, set_day, ltds_pkg::DAY_SUNDAY, hr, mi, se};
        time_load = 1'b1;
        @(negedge clk_sys);
        time_load = 1'b0;
    endtask
    task automatic wait_hour_end();
        for (int k = 0; k < 20000 && {time_now.minute, time_now.second} !== 12'hefb; k++)
            @(negedge clk_sys);
        repeat (6) @(negedge clk_sys);
    endtask
    // Nearest whole minute, carried within the day
    function automatic logic [39:0] snap(input ltds_pkg::ltds_time_t t);
        int s;
        s = t.hour * 3600 + t.minute * 60 + t.second + 30;
        t.hour = 5'(s / 3600);
        t.minute = 6'((s / 60) % 60);
        t.second = 6'h00;
        return t;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        final_report();
    end
    initial begin
        void'($urandom(96372));
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        check("start", 40'(start_now), 40'(ltds_pkg::START_DEFAULT));
        check("end", 40'(end_now), 40'(ltds_pkg::END_DEFAULT));
        check("src", 40'(sync_now), 40'h0);
        check("cty", 40'(country_now), 40'h0);
        start_cfg.hour = 5'h07;
        summer_time_end_date.month = 4'hd;
        do_cfg(4'h8, 2'h0, 8'h00);
        check("start_bad", 40'(start_now), 40'(ltds_pkg::START_DEFAULT));
        check("end_bad", 40'(end_now), 40'(ltds_pkg::END_DEFAULT));
        check("src_bad", 40'(sync_now), 40'h0);
        start_cfg = ltds_pkg::START_DEFAULT;
        summer_time_end_date = '{ltds_pkg::MON_MAR, ltds_pkg::WEEK_SECOND, 3'h0, 5'h04};
        set_time(5'h01, 6'h3b, 6'h3a);
        for (int o = 0; o < 4; o++) begin
            do_cfg(4'h0, 2'(o), 8'($urandom_range(255)));
            if (o == 0) exp_view = {6'h0a, 6'h03, 6'h18};
            else if (o == 1) exp_view = {6'h03, 6'h0a, 6'h18};
            else if (o == 2) exp_view = {6'h18, 6'h03, 6'h0a};
            check("order", 40'(date_view), 40'(exp_view));
            check("cty_set", 40'(country_now), 40'(country_cfg));
        end
        set_time(5'h01, 6'h3b, 6'h3a);
        repeat (10) @(negedge clk_sys);
        check("no_shift", 40'({time_now.hour, time_now.minute}), 40'h080);
        dst_enable = 1'b1;
        set_time(5'h01, 6'h3b, 6'h3a);
        repeat (10) @(negedge clk_sys);
        check("fwd", 40'({time_now.hour, time_now.minute, dst_active}), 40'h181);
        wait_hour_end();
        check("back", 40'({time_now.hour, time_now.minute, dst_active}), 40'h180);
        wait_hour_end();
        check("once", 40'({time_now.hour, time_now.minute}), 40'h100);
        start_cfg.week = ltds_pkg::WEEK_LAST;
        set_day = 5'h19;
        do_cfg(4'h0, 2'h0, 8'h00);
        check("start_set", 40'(start_now), 40'(start_cfg));
        check("end_set", 40'(end_now), 40'(summer_time_end_date));
        set_time(5'h01, 6'h3b, 6'h3a);
        repeat (10) @(negedge clk_sys);
        check("last_wk", 40'({time_now.hour, time_now.minute, dst_active}), 40'h181);
        for (int i = 0; i < 9; i++) begin
            pulse_src = (i < 8) ? srcs[i] : 4'h1;
            do_cfg((i < 8) ? srcs[i] : 4'h0, 2'h0, 8'h00);
            set_time(5'h0a, 6'($urandom_range(59)), 6'($urandom_range(59)));
            width = 4'(2 + $urandom_range(4));
            fire = 1'b1;
            @(negedge clk_sys);
            fire = 1'b0;
            for (int k = 0; k < 20 && sync_hit !== 1'b1; k++) @(negedge clk_sys);
            got = sync_hit;
            check("hit", 40'(got), 40'(i < 8));
            if (i < 8) check("snap", time_now, snap(prev_now));
        end
        final_report();
    end
endmodule
bind ltds_core ltds_monitor u_ltds_monitor (.clk_sys, .rst, .dst_enable, .cfg_load, .country_cfg,
    .time_load, .time_now, .dst_active, .start_now, .end_now, .sync_now, .country_now, .sync_hit);
